/* File: shared/psoc_pkg.sv */
// constants and types for the phase shedding and over-current register bank
package psoc_pkg;
  localparam int unsigned CLK_MHZ = 125;

  localparam logic [7:0] ADDR_R0_CFG  = 8'h06;
  localparam logic [7:0] ADDR_R0_STAT = 8'h07;
  localparam logic [7:0] ADDR_R1_CFG  = 8'h09;
  localparam logic [7:0] ADDR_R1_STAT = 8'h0a;
  localparam logic [7:0] ADDR_R56_CFG = 8'h0d;
  localparam logic [7:0] ADDR_R2_CFG  = 8'h1b;
  localparam logic [7:0] ADDR_R2_STAT = 8'h1c;
  localparam logic [7:0] ADDR_R3_CFG  = 8'h1d;
  localparam logic [7:0] ADDR_R3_STAT = 8'h1e;
  localparam logic [7:0] ADDR_R4_CFG  = 8'h23;
  localparam logic [7:0] ADDR_R4_STAT = 8'h24;
  localparam logic [7:0] ADDR_LIM_BYP = 8'h70;
  localparam logic [7:0] ADDR_LIM_CTL = 8'ha0;
  localparam logic [7:0] ADDR_OC_STAT = 8'hae;

  localparam logic [7:0] RST_CFG012 = 8'h20;
  localparam logic [7:0] RST_CFG34  = 8'h30;
  localparam logic [7:0] RST_CFG56  = 8'h0a;
  localparam logic [7:0] RST_LIMCTL = 8'h67;
  localparam logic [7:0] RST_LIMBYP = 8'h00;
  localparam logic [7:0] RST_STAT   = 8'h00;

  localparam logic [7:0] MASK_CFG012 = 8'h23;
  localparam logic [7:0] MASK_CFG34  = 8'h63;
  localparam logic [7:0] MASK_CFG56  = 8'h0f;
  localparam logic [7:0] MASK_LIMCTL = 8'he0;
  localparam logic [7:0] MASK_LIMBYP = 8'h02;
  localparam logic [7:0] MASK_OC     = 8'h67;
  localparam logic [7:0] LIMCTL_FIXED = 8'h07;

  localparam int unsigned POS_GAIN     = 5;
  localparam int unsigned POS_ALT_COMP = 6;
  localparam int unsigned POS_GM6      = 3;
  localparam int unsigned POS_BW6      = 2;
  localparam int unsigned POS_GM5      = 1;
  localparam int unsigned POS_BW5      = 0;
  localparam int unsigned POS_LONG_BLANK = 7;
  localparam int unsigned POS_EN6      = 6;
  localparam int unsigned POS_EN5      = 5;
  localparam int unsigned POS_GRP_BYP  = 1;

  localparam int unsigned SHED_130_US = 130;
  localparam int unsigned SHED_65_US  = 65;
  localparam int unsigned SHED_20_US  = 20;
  localparam int unsigned BLANK_10_US  = 10;
  localparam int unsigned BLANK_100_US = 100;
  localparam int unsigned SHED_130_CYC = SHED_130_US * CLK_MHZ;
  localparam int unsigned SHED_65_CYC  = SHED_65_US * CLK_MHZ;
  localparam int unsigned SHED_20_CYC  = SHED_20_US * CLK_MHZ;
  localparam int unsigned BLANK_10_CYC  = BLANK_10_US * CLK_MHZ;
  localparam int unsigned BLANK_100_CYC = BLANK_100_US * CLK_MHZ;

  localparam int unsigned CNT_W = 15;

  typedef enum logic [1:0] {
    PSOC_SHED_LONG,
    PSOC_SHED_MID,
    PSOC_SHED_SHORT,
    PSOC_SHED_OFF
  } psoc_shed_type;
endpackage

/* File: src/psoc_shed_timer.sv */
// per rail phase drop timer for the helper units
`timescale 1ns/1ns
module psoc_shed_timer #(
  parameter logic [14:0] SHED_130 = 15'(psoc_pkg::SHED_130_CYC),
  parameter logic [14:0] SHED_65  = 15'(psoc_pkg::SHED_65_CYC),
  parameter logic [14:0] SHED_SH  = 15'(psoc_pkg::SHED_20_CYC),
  parameter bit          SH_ZERO  = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] shed_delay_sel,
  input  wire logic       forced_pwm_sel,
  input  wire logic       light_load,
  output logic            shed_pulse
);
  logic [14:0] cnt_r;
  logic [14:0] limit;
  logic        armed;

  always_comb begin
    case (psoc_pkg::psoc_shed_type'(shed_delay_sel))
      psoc_pkg::PSOC_SHED_LONG:  limit = SHED_130;
      psoc_pkg::PSOC_SHED_MID:   limit = SHED_65;
      psoc_pkg::PSOC_SHED_SHORT: limit = SH_ZERO ? 15'h0000 : SHED_SH;
      default:                   limit = 15'h0000;
    endcase
  end

  // no shedding in forced pwm or with the disable code
  assign armed = light_load && !forced_pwm_sel &&
                 (shed_delay_sel != 2'(psoc_pkg::PSOC_SHED_OFF));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 15'h0000;
    end else if (!armed || cnt_r >= limit) begin
      cnt_r <= 15'h0000;
    end else begin
      cnt_r <= cnt_r + 15'h0001;
    end
  end

  // one pulse per elapsed delay, repeating while light load lasts
  assign shed_pulse = armed && (cnt_r >= limit);
endmodule

/* File: src/psoc_limit_blank.sv */
// blanking counter before warning level limiting starts on one rail
`timescale 1ns/1ns
module psoc_limit_blank (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic long_limit_blanking,
  input  wire logic over_warn,
  output logic      limit_active
);
  logic [14:0] cnt_r;
  logic [14:0] need;

  assign need = long_limit_blanking ? 15'(psoc_pkg::BLANK_100_CYC)
                                    : 15'(psoc_pkg::BLANK_10_CYC);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 15'h0000;
    end else if (!enable || !over_warn) begin
      cnt_r <= 15'h0000;
    end else if (cnt_r < need) begin
      cnt_r <= cnt_r + 15'h0001;
    end
  end

  assign limit_active = enable && over_warn && (cnt_r >= need);
endmodule

/* File: src/psoc_regbank.sv */
// register bank for phase units, compensation and over-current policy
//
// Notes on behaviour
// - rail off: status shows available helper units as thermometer mask
// - rail on: status shows binary count of switching helper units, 0 to 4
// - rails 0-2 shed delay codes: 130, 65, 20 us, or disabled
// - rails 0-2 shedding only in auto pfm/pwm, never in forced pwm
// - rails 3-4 shed delay codes: 130, 65, immediate, or disabled
// - rails 0-4 bit 5 selects gain margin, 1 normal, reset 1
// - rails 3-4 bit 6 selects alternative compensation, reset 0
// - shared rail 5/6 register: bits 3 and 1 are gain margins
// - shared rail 5/6 register: bits 2 and 0 select low bandwidth
// - configuration registers except limit control load their start values from otp storage
// - peak current at warning level sets the warning flag of rails 0-2, 5 and 6; rails 3-4 have no flag
// - warning level limiting active when enable is 1 and bypass 0
// - rails 0-2 limiting starts after 10 or 100 us, by bit 7
// - rails 5-6 limiting bypassed per enable bit or by group bypass
// - warning flag stays set until software writes 1 to it
// - group bypass lives at bit 1, resets 0
// - rail 6 and rail 5 limit enables at bits 6 and 5, reset 1
`timescale 1ns/1ns
module psoc_regbank (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  input  wire logic        otp_load,
  input  wire logic [7:0]  otp_cfg0,
  input  wire logic [7:0]  otp_cfg1,
  input  wire logic [7:0]  otp_cfg2,
  input  wire logic [7:0]  otp_cfg3,
  input  wire logic [7:0]  otp_cfg4,
  input  wire logic [7:0]  otp_cfg56,
  input  wire logic [7:0]  otp_lim_byp,
  input  wire logic [4:0]  rail_on,
  input  wire logic [14:0] units_avail,
  input  wire logic [14:0] units_active,
  input  wire logic [4:0]  forced_pwm_sel,
  input  wire logic [4:0]  light_load,
  input  wire logic [6:0]  peak_over_warn,
  output logic [4:0]       shed_pulse,
  output logic [4:0]       gain_margin_sel,
  output logic [1:0]       alt_comp_sel,
  output logic             rail5_gain_margin_sel,
  output logic             rail6_gain_margin_sel,
  output logic             rail5_low_bandwidth,
  output logic             rail6_low_bandwidth,
  output logic [6:0]       limit_active
);
  logic [7:0] cfg_r [5];
  logic [7:0] cfg56_r;
  logic [7:0] lim_ctl_r;
  logic [7:0] lim_byp_r;
  logic [7:0] oc_r;
  logic [7:0] stat_r [5];
  logic [7:0] rdata_nxt;
  logic [7:0] oc_set;
  logic [7:0] oc_clr;
  logic [6:0] lim_en;

  function automatic logic [7:0] thermo(input logic [2:0] n);
    case (n)
      3'h0:    thermo = 8'h00;
      3'h1:    thermo = 8'h01;
      3'h2:    thermo = 8'h03;
      3'h3:    thermo = 8'h07;
      default: thermo = 8'h0f;
    endcase
  endfunction

  function automatic logic [7:0] clamp4(input logic [2:0] n);
    clamp4 = (n > 3'h4) ? 8'h04 : {5'h00, n};
  endfunction

  function automatic logic [7:0] cfg_addr(input int i);
    case (i)
      0:       cfg_addr = psoc_pkg::ADDR_R0_CFG;
      1:       cfg_addr = psoc_pkg::ADDR_R1_CFG;
      2:       cfg_addr = psoc_pkg::ADDR_R2_CFG;
      3:       cfg_addr = psoc_pkg::ADDR_R3_CFG;
      default: cfg_addr = psoc_pkg::ADDR_R4_CFG;
    endcase
  endfunction

  function automatic logic [7:0] otp_sel(input int i, input logic [7:0] a, input logic [7:0] b,
                                         input logic [7:0] c, input logic [7:0] d,
                                         input logic [7:0] e);
    case (i)
      0:       otp_sel = a;
      1:       otp_sel = b;
      2:       otp_sel = c;
      3:       otp_sel = d;
      default: otp_sel = e;
    endcase
  endfunction

  // rail compensation and shed delay registers
  for (genvar i = 0; i < 5; i++) begin : g_rail
    localparam logic [7:0] RST  = (i < 3) ? psoc_pkg::RST_CFG012 : psoc_pkg::RST_CFG34;
    localparam logic [7:0] MASK = (i < 3) ? psoc_pkg::MASK_CFG012 : psoc_pkg::MASK_CFG34;
    localparam logic [7:0] FIX  = (i < 3) ? 8'h00 : 8'h10;

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cfg_r[i] <= RST;
      end else if (otp_load) begin
        cfg_r[i] <= (otp_sel(i, otp_cfg0, otp_cfg1, otp_cfg2, otp_cfg3, otp_cfg4) & MASK)
                    | FIX;
      end else if (reg_wr && reg_addr == cfg_addr(i)) begin
        cfg_r[i] <= (reg_wdata & MASK) | FIX;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        stat_r[i] <= psoc_pkg::RST_STAT;
      end else if (rail_on[i]) begin
        stat_r[i] <= clamp4(units_active[3*i +: 3]);
      end else begin
        stat_r[i] <= thermo(units_avail[3*i +: 3]);
      end
    end

    psoc_shed_timer #(
      .SH_ZERO (i >= 3)
    ) u_shed (
      .clk            (clk),
      .rst_n          (rst_n),
      .shed_delay_sel (cfg_r[i][1:0]),
      .forced_pwm_sel (forced_pwm_sel[i]),
      .light_load     (light_load[i]),
      .shed_pulse     (shed_pulse[i])
    );

    assign gain_margin_sel[i] = cfg_r[i][psoc_pkg::POS_GAIN];
  end

  assign alt_comp_sel[0] = cfg_r[3][psoc_pkg::POS_ALT_COMP];
  assign alt_comp_sel[1] = cfg_r[4][psoc_pkg::POS_ALT_COMP];

  // shared rail 5/6 compensation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg56_r <= psoc_pkg::RST_CFG56;
    end else if (otp_load) begin
      cfg56_r <= otp_cfg56 & psoc_pkg::MASK_CFG56;
    end else if (reg_wr && reg_addr == psoc_pkg::ADDR_R56_CFG) begin
      cfg56_r <= reg_wdata & psoc_pkg::MASK_CFG56;
    end
  end

  assign rail6_gain_margin_sel = cfg56_r[psoc_pkg::POS_GM6];
  assign rail5_gain_margin_sel = cfg56_r[psoc_pkg::POS_GM5];
  assign rail6_low_bandwidth   = cfg56_r[psoc_pkg::POS_BW6];
  assign rail5_low_bandwidth   = cfg56_r[psoc_pkg::POS_BW5];

  // limit control; low bits always read back the fixed pattern
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lim_ctl_r <= psoc_pkg::RST_LIMCTL;
    end else if (reg_wr && reg_addr == psoc_pkg::ADDR_LIM_CTL) begin
      lim_ctl_r <= (reg_wdata & psoc_pkg::MASK_LIMCTL) | psoc_pkg::LIMCTL_FIXED;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lim_byp_r <= psoc_pkg::RST_LIMBYP;
    end else if (otp_load) begin
      lim_byp_r <= otp_lim_byp & psoc_pkg::MASK_LIMBYP;
    end else if (reg_wr && reg_addr == psoc_pkg::ADDR_LIM_BYP) begin
      lim_byp_r <= reg_wdata & psoc_pkg::MASK_LIMBYP;
    end
  end

  // rails 0-2 and 3-4 have no enable bit here and limit at warning level
  always_comb begin
    lim_en = 7'h1f;
    lim_en[5] = lim_ctl_r[psoc_pkg::POS_EN5] &&
                !lim_byp_r[psoc_pkg::POS_GRP_BYP];
    lim_en[6] = lim_ctl_r[psoc_pkg::POS_EN6] &&
                !lim_byp_r[psoc_pkg::POS_GRP_BYP];
  end

  for (genvar j = 0; j < 3; j++) begin : g_blank
    psoc_limit_blank u_blank (
      .clk                 (clk),
      .rst_n               (rst_n),
      .enable              (lim_en[j]),
      .long_limit_blanking (lim_ctl_r[psoc_pkg::POS_LONG_BLANK]),
      .over_warn           (peak_over_warn[j]),
      .limit_active        (limit_active[j])
    );
  end

  assign limit_active[3] = lim_en[3] && peak_over_warn[3];
  assign limit_active[4] = lim_en[4] && peak_over_warn[4];
  assign limit_active[5] = lim_en[5] && peak_over_warn[5];
  assign limit_active[6] = lim_en[6] && peak_over_warn[6];

  // warning flags: set wins over a write-one clear in the same cycle
  assign oc_set = {1'b0, peak_over_warn[6:5], 2'b00, peak_over_warn[2:0]}
                  & psoc_pkg::MASK_OC;
  assign oc_clr = (reg_wr && reg_addr == psoc_pkg::ADDR_OC_STAT) ?
                  (reg_wdata & psoc_pkg::MASK_OC) : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_r <= 8'h00;
    end else begin
      oc_r <= (oc_r & ~oc_clr) | oc_set;
    end
  end

  always_comb begin
    case (reg_addr)
      psoc_pkg::ADDR_R0_CFG:  rdata_nxt = cfg_r[0];
      psoc_pkg::ADDR_R1_CFG:  rdata_nxt = cfg_r[1];
      psoc_pkg::ADDR_R2_CFG:  rdata_nxt = cfg_r[2];
      psoc_pkg::ADDR_R3_CFG:  rdata_nxt = cfg_r[3];
      psoc_pkg::ADDR_R4_CFG:  rdata_nxt = cfg_r[4];
      psoc_pkg::ADDR_R0_STAT: rdata_nxt = stat_r[0];
      psoc_pkg::ADDR_R1_STAT: rdata_nxt = stat_r[1];
      psoc_pkg::ADDR_R2_STAT: rdata_nxt = stat_r[2];
      psoc_pkg::ADDR_R3_STAT: rdata_nxt = stat_r[3];
      psoc_pkg::ADDR_R4_STAT: rdata_nxt = stat_r[4];
      psoc_pkg::ADDR_R56_CFG: rdata_nxt = cfg56_r;
      psoc_pkg::ADDR_LIM_CTL: rdata_nxt = lim_ctl_r;
      psoc_pkg::ADDR_LIM_BYP: rdata_nxt = lim_byp_r;
      psoc_pkg::ADDR_OC_STAT: rdata_nxt = oc_r;
      default:                rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end
endmodule

/* File: sim/psoc_regbank_chk.sv */
// assertion checker for the phase shedding and over-current register bank
`timescale 1ns/1ns
module psoc_regbank_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        otp_load,
  input wire logic [4:0]  rail_on,
  input wire logic [14:0] units_avail,
  input wire logic [4:0]  forced_pwm_sel,
  input wire logic [4:0]  light_load,
  input wire logic [6:0]  peak_over_warn,
  input wire logic [4:0]  shed_pulse,
  input wire logic [4:0]  gain_margin_sel,
  input wire logic [1:0]  alt_comp_sel,
  input wire logic        rail5_gain_margin_sel,
  input wire logic        rail6_gain_margin_sel,
  input wire logic        rail5_low_bandwidth,
  input wire logic        rail6_low_bandwidth,
  input wire logic [6:0]  limit_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // consecutive cycles of rail 0 over warning, saturating
  logic [13:0] warn_run_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_run_r <= 14'h0;
    end else if (!peak_over_warn[0]) begin
      warn_run_r <= 14'h0;
    end else if (warn_run_r != 14'h3fff) begin
      warn_run_r <= warn_run_r + 14'h1;
    end
  end
  function automatic logic [7:0] therm(input logic [2:0] n);
    return (n > 3'h4) ? 8'h0f : ((8'h01 << n) - 8'h01);
  endfunction
  sequence cfg_wr_s(logic [7:0] a);
    reg_wr && !otp_load && reg_addr == a;
  endsequence
  shed_gate_a: assert property ((shed_pulse & (~light_load | forced_pwm_sel)) == 5'h00)
    else $error("shed pulse while not armed");
  shed_space_a: assert property (shed_pulse[0] |=> (!shed_pulse[0]) [*8])
    else $error("rail 0 shed pulses too close");
  warn_blank_a: assert property (limit_active[0] |-> warn_run_r >= 14'h4e0)
    else $error("rail 0 limiting before blanking time");
  direct_limit_a: assert property (limit_active[4:3] == peak_over_warn[4:3])
    else $error("rail 3 or 4 limiting not following warning");
  pair_limit_a: assert property ((limit_active[6:5] & ~peak_over_warn[6:5]) == 2'h0)
    else $error("rail 5 or 6 limiting without warning");
  gain_wr_a: assert property (cfg_wr_s(psoc_pkg::ADDR_R0_CFG)
    |=> gain_margin_sel[0] == $past(reg_wdata[5])) else $error("rail 0 gain not written");
  alt_wr_a: assert property (cfg_wr_s(psoc_pkg::ADDR_R3_CFG)
    |=> alt_comp_sel[0] == $past(reg_wdata[6])) else $error("rail 3 comp not written");
  pair_cfg_a: assert property (cfg_wr_s(psoc_pkg::ADDR_R56_CFG) |=>
    {rail6_gain_margin_sel, rail6_low_bandwidth, rail5_gain_margin_sel, rail5_low_bandwidth}
    == $past(reg_wdata[3:0])) else $error("rail 5 and 6 settings not written");
  reset_lvl_a: assert property ($rose(rst_n) |-> gain_margin_sel == 5'h1f &&
    alt_comp_sel == 2'h0 && {rail6_gain_margin_sel, rail5_gain_margin_sel} == 2'h3)
    else $error("control levels wrong after reset");
  status_off_a: assert property (reg_rd && reg_addr == psoc_pkg::ADDR_R0_STAT &&
    !rail_on[0] && $past(rst_n) && $stable(rail_on[0]) && $stable(units_avail[2:0])
    |=> reg_rdata == therm($past(units_avail[2:0]))) else $error("rail 0 mask wrong");
endmodule
bind psoc_regbank psoc_regbank_chk chk (.*);

/* File: sim/phase_shed_overcurrent_ctrl_bench.sv */
// self-checking bench for the phase shedding and over-current register bank
`timescale 1ns/1ns
module phase_shed_overcurrent_ctrl_bench;
  logic        clk, rst_n, reg_wr, reg_rd, otp_load;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, otp_cfg0, otp_cfg1, otp_cfg2;
  logic [7:0]  otp_cfg3, otp_cfg4, otp_cfg56, otp_lim_byp;
  logic [4:0]  rail_on, forced_pwm_sel, light_load, shed_pulse, gain_margin_sel;
  logic [14:0] units_avail, units_active;
  logic [6:0]  peak_over_warn, limit_active;
  logic [1:0]  alt_comp_sel;
  logic        rail5_gain_margin_sel, rail6_gain_margin_sel;
  logic        rail5_low_bandwidth, rail6_low_bandwidth;
  int          failures, samples_checked;
  localparam logic [7:0] RA [11] = '{8'h06, 8'h09, 8'h0d, 8'h1b, 8'h1d, 8'h23,
                                     8'ha0, 8'h70, 8'hae, 8'h07, 8'h50};
  localparam logic [7:0] RE [11] = '{8'h20, 8'h20, 8'h0a, 8'h20, 8'h30, 8'h30,
                                     8'h67, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] LL [4] = '{8'h67, 8'h47, 8'h27, 8'h67};
  localparam logic [7:0] LB [4] = '{8'h00, 8'h00, 8'h00, 8'h02};
  localparam logic [7:0] LX [4] = '{8'h03, 8'h02, 8'h01, 8'h00};
  localparam int SC [3] = '{130 * 125, 65 * 125, 20 * 125};
  psoc_regbank dut (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  // cycles until rail 0 sheds (sel 0) or limits (sel 1), within three cycles
  task automatic lat(input int sel, input int exp);
    int n;
    n = 0;
    while (n < 17000 && (sel ? limit_active[0] : shed_pulse[0]) !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    if (n >= 17000) begin
      failures++;
      wrap_up();
    end
    chk({7'h00, n >= exp - 3 && n <= exp + 3}, 8'h01);
  endtask
  task automatic quiet(input int cyc);
    int hits;
    hits = 0;
    repeat (cyc) begin
      @(negedge clk);
      hits += (shed_pulse !== 5'h00);
    end
    chk(8'(hits), 8'h00);
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, otp_load} = 4'h0;
    {reg_addr, reg_wdata, otp_cfg0, otp_cfg1, otp_cfg2, otp_cfg3} = '0;
    {otp_cfg4, otp_cfg56, otp_lim_byp, units_avail, units_active} = '0;
    {rail_on, forced_pwm_sel, light_load, peak_over_warn} = '0;
    {failures, samples_checked} = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 11; i++) rc(RA[i], RE[i]);
    $display("test reset values done");
    wr(8'h06, 8'h00);
    rc(8'h06, 8'h00);
    chk({3'h0, gain_margin_sel}, 8'h1e);
    wr(8'h1d, 8'hff);
    rc(8'h1d, 8'h73);
    chk({6'h0, alt_comp_sel}, 8'h01);
    wr(8'h0d, 8'h05);
    chk({4'h0, rail6_gain_margin_sel, rail6_low_bandwidth, rail5_gain_margin_sel,
         rail5_low_bandwidth}, 8'h05);
    wr(8'ha0, 8'h00);
    rc(8'ha0, 8'h07);
    wr(8'h70, 8'hff);
    rc(8'h70, 8'h02);
    wr(8'h07, 8'hff);
    rc(8'h07, 8'h00);
    $display("test register access done");
    for (int n = 0; n < 7; n++) begin
      rail_on = 5'h00;
      units_avail = 15'(n);
      if (n < 5) rc(8'h07, (8'h01 << n) - 8'h01);
      rail_on = 5'h01;
      units_active = 15'(n);
      rc(8'h07, (n > 4) ? 8'h04 : 8'(n));
    end
    {rail_on, units_avail, units_active} = {5'h08, 15'h0600, 15'h0400};
    rc(8'h1e, 8'h02);
    rail_on = 5'h00;
    rc(8'h1e, 8'h07);
    $display("test status done");
    wr(8'h1d, 8'h02);
    light_load = 5'h08;
    @(negedge clk);
    chk({7'h0, shed_pulse[3]}, 8'h01);
    forced_pwm_sel = 5'h08;
    quiet(20);
    forced_pwm_sel = 5'h00;
    wr(8'h1d, 8'h03);
    quiet(200);
    light_load = 5'h00;
    for (int c = 0; c < 3; c++) begin
      wr(8'h06, 8'(c));
      light_load = 5'h01;
      lat(0, SC[c]);
      light_load = 5'h00;
    end
    wr(8'h06, 8'h03);
    light_load = 5'h01;
    quiet(3000);
    wr(8'h06, 8'h02);
    forced_pwm_sel = 5'h01;
    quiet(3000);
    {forced_pwm_sel, light_load} = '0;
    $display("test shedding done");
    peak_over_warn = 7'h21;
    @(negedge clk);
    peak_over_warn = 7'h00;
    rc(8'hae, 8'h21);
    wr(8'hae, 8'h01);
    rc(8'hae, 8'h20);
    wr(8'hae, 8'h20);
    rc(8'hae, 8'h00);
    peak_over_warn = 7'h18;
    @(negedge clk);
    chk({6'h0, limit_active[4:3]}, 8'h03);
    peak_over_warn = 7'h60;
    for (int i = 0; i < 4; i++) begin
      wr(8'ha0, LL[i]);
      wr(8'h70, LB[i]);
      @(negedge clk);
      chk({6'h0, limit_active[6:5]}, LX[i]);
    end
    wr(8'h70, 8'h00);
    wr(8'ha0, 8'h67);
    peak_over_warn = 7'h01;
    lat(1, 10 * 125);
    peak_over_warn = 7'h00;
    wr(8'ha0, 8'he7);
    peak_over_warn = 7'h01;
    lat(1, 100 * 125);
    peak_over_warn = 7'h00;
    $display("test over-current done");
    {otp_cfg0, otp_cfg3, otp_cfg56, otp_lim_byp} = 32'hff00ffff;
    @(negedge clk);
    otp_load = 1'b1;
    @(negedge clk);
    otp_load = 1'b0;
    rc(8'h06, 8'h23);
    rc(8'h1d, 8'h10);
    rc(8'h0d, 8'h0f);
    rc(8'h70, 8'h02);
    $display("test start-up load done");
    wrap_up();
  end
endmodule
